// [core/serial_txn.sv]
// master transaction sequencer plus slave reply decision
`timescale 1ns/1ps
module serial_txn #(
    parameter int REPLY_TMO_CYC = txn_pkg::REPLY_TMO_CYC,
    parameter int BCAST_GAP_CYC = txn_pkg::BCAST_GAP_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // master request side
    input  wire logic       req_valid,
    input  wire logic [7:0] req_addr,
    input  wire logic [7:0] req_func,
    input  wire logic       req_is_write,
    input  wire logic [3:0] retry_max,
    input  wire logic       retry_on_frame_err,
    // frame summary from the receive path
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_addr,
    input  wire logic [7:0] rx_func,
    input  wire logic       rx_parity_err,
    input  wire logic       rx_check_err,
    // slave side
    input  wire logic       slave_mode,
    input  wire logic [7:0] my_addr,
    input  wire logic       req_bad_format,
    // master outputs
    output logic            req_ready,
    output logic            tx_start,
    output logic [7:0]      tx_addr,
    output logic [7:0]      tx_func,
    output logic            reply_ok,
    output logic [7:0]      reply_func,
    output logic            txn_err,
    output logic            timeout_err,
    output logic            retries_exhausted,
    output logic            busy,
    // slave outputs
    output logic            slv_exec,
    output logic            slv_exec_bcast,
    output logic            slv_reply,
    output logic            slv_reply_err,
    output logic [7:0]      slv_reply_addr
);
    rx_frame_if fr ();

    logic m_valid;
    logic s_valid;

    // one receive stage feeds both roles
    frame_screen u_screen (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .in_valid      (rx_valid),
        .in_addr       (rx_addr),
        .in_func       (rx_func),
        .in_parity_err (rx_parity_err),
        .in_check_err  (rx_check_err),
        .fr            (fr)
    );

    // slave decision block, registered outputs
    logic       sx_q, sb_q, sr_q, se_q;
    logic [7:0] sa_q;
    logic       sx_w, sb_w, sr_w, se_w;
    logic [7:0] sa_w;
    logic       sx_d, sb_d, sr_d, se_d;
    logic [7:0] sa_d;

    slave_decide u_slave (
        .ref_clk        (ref_clk),
        .srst           (srst),
        .my_addr        (my_addr),
        .req_bad_format (req_bad_format),
        .fr             (fr),
        .exec_req       (sx_w),
        .exec_bcast     (sb_w),
        .reply_req      (sr_w),
        .reply_err      (se_w),
        .reply_addr     (sa_w)
    );

    // gate slave results so a master never answers anyone
    always_comb begin
        s_valid = slave_mode;
        sx_d    = sx_w & s_valid;
        sb_d    = sb_w & s_valid;
        sr_d    = sr_w & s_valid;
        se_d    = se_w & s_valid;
        sa_d    = sa_w;
    end

    // third stage keeps every slave output on a flop
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sx_q <= 1'b0;
            sb_q <= 1'b0;
            sr_q <= 1'b0;
            se_q <= 1'b0;
            sa_q <= 8'h00;
        end else begin
            sx_q <= sx_d;
            sb_q <= sb_d;
            sr_q <= sr_d;
            se_q <= se_d;
            sa_q <= sa_d;
        end
    end

    // slave outputs
    assign slv_exec       = sx_q;
    assign slv_exec_bcast = sb_q;
    assign slv_reply      = sr_q;
    assign slv_reply_err  = se_q;
    assign slv_reply_addr = sa_q;

    // ---- master sequencer ----
    txn_pkg::mstate_e st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [3:0]  tries_q, tries_d;
    logic [7:0]  dst_q, dst_d;
    logic [7:0]  fn_q, fn_d;

    // output flops of the master
    logic        rdy_q, rdy_d;
    logic        txs_q, txs_d;
    logic        ok_q, ok_d;
    logic [7:0]  rfn_q, rfn_d;
    logic        err_q, err_d;
    logic        tmo_q, tmo_d;
    logic        exh_q, exh_d;
    logic        busy_q, busy_d;
    logic        launch;
    logic        req_legal;

    // gap only covers processing, so it never outlasts the timeout
    localparam int GAP_CYC = (BCAST_GAP_CYC < REPLY_TMO_CYC) ? BCAST_GAP_CYC : REPLY_TMO_CYC;

    // a frame counts only when it names the slave we addressed
    function automatic logic from_target(input logic v, input logic [7:0] a,
                                         input logic [7:0] d);
        return v && (a == d);
    endfunction : from_target

    // master sees frames only in master role
    assign m_valid = fr.valid & ~slave_mode;
    // broadcast must be a write; reserved targets are refused, master has no address
    assign req_legal = (txn_pkg::addr_class(req_addr) == txn_pkg::A_INDIV)
                     | ((txn_pkg::addr_class(req_addr) == txn_pkg::A_BCAST)
                        & req_is_write);
    assign launch = req_valid & rdy_q & ~slave_mode;

    // next-state and timers; refused requests raise txn_err only
    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q;
        tries_d = tries_q;
        dst_d   = dst_q;
        fn_d    = fn_q;
        txs_d   = 1'b0;
        ok_d    = 1'b0;
        rfn_d   = rfn_q;
        err_d   = 1'b0;
        tmo_d   = 1'b0;
        exh_d   = 1'b0;
        case (st_q)
            txn_pkg::M_IDLE: begin
                if (launch && !req_legal) begin
                    err_d = 1'b1;
                end else if (launch) begin
                    dst_d = req_addr;
                    fn_d  = req_func;
                    txs_d = 1'b1;
                    // same target resends count as retries
                    tries_d = (req_addr == dst_q) ? tries_q : 4'h0;
                    // broadcast waits out the gap, unicast waits for a reply
                    if (req_addr == txn_pkg::ADDR_BCAST) begin
                        st_d  = txn_pkg::M_WAIT_GAP;
                        tmr_d = 32'(GAP_CYC);
                    end else begin
                        st_d  = txn_pkg::M_WAIT_REPLY;
                        tmr_d = 32'(REPLY_TMO_CYC);
                    end
                end
            end

            txn_pkg::M_WAIT_REPLY: begin
                tmr_d = tmr_q - 32'h1; // wrong-slave replies fall through here
                if (from_target(m_valid, fr.addr, dst_q) && fr.frame_err) begin
                    // resend while tries remain, else give up
                    if (retry_on_frame_err && tries_q < retry_max) begin
                        txs_d   = 1'b1; // resend same request
                        tries_d = tries_q + 4'h1;
                        tmr_d   = 32'(REPLY_TMO_CYC);
                    end else begin
                        err_d = 1'b1;
                        st_d  = txn_pkg::M_IDLE;
                    end
                end else if (from_target(m_valid, fr.addr, dst_q)) begin
                    ok_d    = 1'b1;
                    rfn_d   = fr.func;
                    tries_d = 4'h0;
                    tmr_d   = 32'h0;
                    st_d    = txn_pkg::M_IDLE;
                end else if (tmr_q <= 32'h1) begin
                    err_d   = 1'b1;
                    tmo_d   = 1'b1;
                    st_d    = txn_pkg::M_IDLE;
                    // count the attempt so the next resend sees the ceiling
                    tries_d = (tries_q < 4'hF) ? tries_q + 4'h1 : tries_q;
                    exh_d   = (tries_q >= retry_max);
                end
            end

            // frames are ignored while the gap runs
            txn_pkg::M_WAIT_GAP: begin
                tmr_d = tmr_q - 32'h1;
                if (tmr_q <= 32'h1) begin
                    st_d  = txn_pkg::M_IDLE;
                    tmr_d = 32'h0;
                end
            end

            // a stray state code falls back to idle
            default: begin
                st_d = txn_pkg::M_IDLE;
            end
        endcase
        // ready follows the next state, so idle shows at once
        rdy_d  = (st_d == txn_pkg::M_IDLE) & ~slave_mode;
        busy_d = (st_d != txn_pkg::M_IDLE);
    end

    // register stage only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q    <= txn_pkg::M_IDLE;
            tmr_q   <= 32'h0;
            tries_q <= 4'h0;
            dst_q   <= 8'h00;
            fn_q    <= 8'h00;
            rdy_q   <= 1'b0;
            txs_q   <= 1'b0;
            ok_q    <= 1'b0;
            rfn_q   <= 8'h00;
            err_q   <= 1'b0;
            tmo_q   <= 1'b0;
            exh_q   <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            tries_q <= tries_d;
            dst_q   <= dst_d;
            fn_q    <= fn_d;
            rdy_q   <= rdy_d;
            txs_q   <= txs_d;
            ok_q    <= ok_d;
            rfn_q   <= rfn_d;
            err_q   <= err_d;
            tmo_q   <= tmo_d;
            exh_q   <= exh_d;
            busy_q  <= busy_d;
        end
    end

    // master outputs
    assign req_ready         = rdy_q;
    assign tx_start          = txs_q;
    assign tx_addr           = dst_q;
    assign tx_func           = fn_q;
    assign reply_ok          = ok_q;
    assign reply_func        = rfn_q;
    assign txn_err           = err_q;
    assign timeout_err       = tmo_q;
    assign retries_exhausted = exh_q;
    assign busy              = busy_q;
endmodule : serial_txn

// [include/txn_pkg.sv]
// constants and types for the serial master/slave transaction layer
package txn_pkg;

    localparam int          CLK_HZ            = 125_000_000;
    localparam int          ADDR_W            = 8;
    localparam int          FUNC_W            = 8;
    localparam logic [7:0]  ADDR_BCAST        = 8'h00;
    localparam logic [7:0]  ADDR_IND_LO       = 8'h01;
    localparam logic [7:0]  ADDR_IND_HI       = 8'hF7;
    localparam logic [7:0]  ADDR_RSVD_LO      = 8'hF8;
    localparam int          MAX_SLAVES        = 247;

    // default timings: reply timeout 1 s, broadcast gap 100 ms
    localparam int          REPLY_TMO_MS      = 1000;
    localparam int          BCAST_GAP_MS      = 100;
    localparam int          REPLY_TMO_CYC     = REPLY_TMO_MS * (CLK_HZ / 1000);
    localparam int          BCAST_GAP_CYC     = BCAST_GAP_MS * (CLK_HZ / 1000);
    localparam int          TMR_W             = 32;
    localparam int          RETRY_W           = 4;
    localparam logic [3:0]  RETRY_MAX_RST     = 4'h3;

    // master transaction states
    typedef enum logic [1:0] {
        M_IDLE,
        M_WAIT_REPLY,
        M_WAIT_GAP
    } mstate_e;

    // address classes
    typedef enum logic [1:0] {
        A_BCAST,
        A_INDIV,
        A_RSVD
    } aclass_e;

    // classify an address byte
    function automatic aclass_e addr_class(input logic [7:0] a);
        if (a == ADDR_BCAST) begin
            return A_BCAST;
        end else if (a <= ADDR_IND_HI) begin
            return A_INDIV;
        end else begin
            return A_RSVD;
        end
    endfunction : addr_class

endpackage : txn_pkg

// [include/rx_frame_if.sv]
// received-frame summary passed from the screening logic
`timescale 1ns/1ps
interface rx_frame_if;
    logic       valid;
    logic [7:0] addr;
    logic [7:0] func;
    logic       parity_err;
    logic       check_err;
    logic       frame_err;
    modport src (output valid, output addr, output func, output parity_err,
                 output check_err, output frame_err);
    modport dst (input valid, input addr, input func, input parity_err,
                 input check_err, input frame_err);
endinterface : rx_frame_if

// [core/frame_screen.sv]
// registers an incoming frame summary and derives its frame error
`timescale 1ns/1ps
module frame_screen (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_addr,
    input  wire logic [7:0] in_func,
    input  wire logic       in_parity_err,
    input  wire logic       in_check_err,
    rx_frame_if.src         fr
);
    logic       valid_q, valid_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] func_q, func_d;
    logic       par_q, par_d;
    logic       chk_q, chk_d;

    // capture only on a frame end strobe
    always_comb begin
        valid_d = in_valid;
        addr_d  = in_valid ? in_addr : addr_q;
        func_d  = in_valid ? in_func : func_q;
        par_d   = in_valid ? in_parity_err : par_q;
        chk_d   = in_valid ? in_check_err : chk_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            valid_q <= 1'b0;
            addr_q  <= 8'h00;
            func_q  <= 8'h00;
            par_q   <= 1'b0;
            chk_q   <= 1'b0;
        end else begin
            valid_q <= valid_d;
            addr_q  <= addr_d;
            func_q  <= func_d;
            par_q   <= par_d;
            chk_q   <= chk_d;
        end
    end

    assign fr.valid      = valid_q;
    assign fr.addr       = addr_q;
    assign fr.func       = func_q;
    assign fr.parity_err = par_q;
    assign fr.check_err  = chk_q;
    assign fr.frame_err  = par_q | chk_q;
endmodule : frame_screen

// [core/slave_decide.sv]
// slave-side addressing and reply decision
`timescale 1ns/1ps
module slave_decide (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [7:0] my_addr,
    input  wire logic       req_bad_format,
    rx_frame_if.dst         fr,
    output logic            exec_req,
    output logic            exec_bcast,
    output logic            reply_req,
    output logic            reply_err,
    output logic [7:0]      reply_addr
);
    logic       exec_q, exec_d;
    logic       bc_q, bc_d;
    logic       rep_q, rep_d;
    logic       rerr_q, rerr_d;
    logic [7:0] raddr_q, raddr_d;
    logic       mine;
    logic       is_bc;
    logic       addr_ok;

    // own address must be individual to be assignable
    assign addr_ok = (txn_pkg::addr_class(my_addr) == txn_pkg::A_INDIV);
    assign is_bc   = (txn_pkg::addr_class(fr.addr) == txn_pkg::A_BCAST);
    assign mine    = addr_ok && (fr.addr == my_addr);

    // replies only follow a master request, never on broadcast or bad frame
    always_comb begin
        exec_d  = 1'b0;
        bc_d    = 1'b0;
        rep_d   = 1'b0;
        rerr_d  = 1'b0;
        raddr_d = raddr_q;
        if (fr.valid && !fr.frame_err) begin
            if (is_bc) begin
                exec_d = !req_bad_format;
                bc_d   = !req_bad_format;
            end else if (mine) begin
                exec_d  = !req_bad_format;
                rep_d   = 1'b1;
                rerr_d  = req_bad_format;
                raddr_d = my_addr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            exec_q  <= 1'b0;
            bc_q    <= 1'b0;
            rep_q   <= 1'b0;
            rerr_q  <= 1'b0;
            raddr_q <= 8'h00;
        end else begin
            exec_q  <= exec_d;
            bc_q    <= bc_d;
            rep_q   <= rep_d;
            rerr_q  <= rerr_d;
            raddr_q <= raddr_d;
        end
    end

    assign exec_req   = exec_q;
    assign exec_bcast = bc_q;
    assign reply_req  = rep_q;
    assign reply_err  = rerr_q;
    assign reply_addr = raddr_q;
endmodule : slave_decide

// [sim/serial_txn_asserts.sv]
// concurrent checks on the transaction sequencer ports
`timescale 1ns/1ps
module serial_txn_asserts (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       req_valid,
    input wire logic [7:0] req_addr,
    input wire logic       req_is_write,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_addr,
    input wire logic       rx_parity_err,
    input wire logic       rx_check_err,
    input wire logic       slave_mode,
    input wire logic [7:0] my_addr,
    input wire logic       req_ready,
    input wire logic       tx_start,
    input wire logic [7:0] tx_addr,
    input wire logic       reply_ok,
    input wire logic       txn_err,
    input wire logic       timeout_err,
    input wire logic       busy,
    input wire logic       slv_reply,
    input wire logic [7:0] slv_reply_addr
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // a request offered while the master sits idle
    wire logic take = req_valid && req_ready && !slave_mode;

    // launch, refusal and occupancy of the master
    launch_a: assert property (
        take && req_addr != 8'h00 && req_addr < 8'hF8 |=> tx_start && tx_addr == $past(req_addr))
        else $error("unicast request not launched");
    rsvd_refuse_a: assert property (
        take && req_addr >= 8'hF8 |=> txn_err && !tx_start)
        else $error("reserved address launched");
    bcast_write_a: assert property (
        take && req_addr == 8'h00 && !req_is_write |=> txn_err && !tx_start)
        else $error("broadcast read launched");
    one_txn_a: assert property (
        tx_start |-> busy && !req_ready)
        else $error("launch left master ready");
    bcast_gap_a: assert property (
        tx_start && tx_addr == 8'h00 |=> (busy && !reply_ok) [*8])
        else $error("broadcast gap cut short");
    // replies: source screening and timeout exit
    reply_src_a: assert property (
        reply_ok |-> $past(rx_valid, 2) && $past(rx_addr, 2) == tx_addr)
        else $error("reply taken from wrong node");
    tmo_idle_a: assert property (
        timeout_err |-> txn_err ##1 req_ready)
        else $error("timeout did not end transaction");
    slv_cause_a: assert property (
        slv_reply |-> $past(rx_valid, 3) && $past(rx_addr, 3) == my_addr
            && !$past(rx_parity_err, 3) && !$past(rx_check_err, 3) && slv_reply_addr == my_addr)
        else $error("slave reply without clean own request");

    uni_c: cover property (reply_ok);
    tmo_c: cover property (timeout_err);
    slv_c: cover property (slv_reply);
endmodule : serial_txn_asserts

bind serial_txn serial_txn_asserts serial_txn_asserts_inst (
    .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req_addr(req_addr),
    .req_is_write(req_is_write), .rx_valid(rx_valid), .rx_addr(rx_addr),
    .rx_parity_err(rx_parity_err), .rx_check_err(rx_check_err), .slave_mode(slave_mode),
    .my_addr(my_addr), .req_ready(req_ready), .tx_start(tx_start), .tx_addr(tx_addr),
    .reply_ok(reply_ok), .txn_err(txn_err), .timeout_err(timeout_err), .busy(busy),
    .slv_reply(slv_reply), .slv_reply_addr(slv_reply_addr)
);

// [sim/slave_node_model.sv]
// behavioural slave node on the far side of the master
`timescale 1ns/1ps
module slave_node_model (
    input  wire logic       ref_clk,
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_addr,
    input  wire logic [7:0] tx_func,
    input  wire logic [1:0] mode,   // 0 good, 1 wrong node, 2 one damaged reply, 3 mute
    input  wire logic [7:0] dly,
    output logic            rx_valid = 1'b0,
    output logic [7:0]      rx_addr = 8'hA5,
    output logic [7:0]      rx_func = 8'h5A,
    output logic            rx_check_err = 1'b0
);
    logic err_sent = 1'b0;

    // one answer per unicast request unless mode 3 mutes it, after the processing delay
    always @(posedge ref_clk) begin
        if (tx_start === 1'b1 && tx_addr != 8'h00 && mode != 2'h3) begin
            repeat (dly) @(posedge ref_clk);
            rx_valid     <= 1'b1;
            rx_addr      <= (mode == 2'h1) ? tx_addr + 8'h01 : tx_addr;
            rx_func      <= tx_func;
            rx_check_err <= mode == 2'h2 && !err_sent;
            err_sent = mode == 2'h2;
            @(posedge ref_clk);
            rx_valid     <= 1'b0;
            rx_addr      <= ~rx_addr;   // released lines never keep the old frame
            rx_func      <= ~rx_func;
            rx_check_err <= ~rx_check_err;
        end else if (mode != 2'h2) begin
            err_sent = 1'b0;
        end
    end
endmodule : slave_node_model

// [sim/testbench.sv]
// self-checking bench for the transaction sequencer
`timescale 1ns/1ps
module testbench;
    logic       ref_clk = 1'b0;
    logic       srst = 1'b1;
    logic       req_valid = 1'b0;
    logic       req_is_write = 1'b0;
    logic       retry_on_frame_err = 1'b0;
    logic       slave_mode = 1'b0;
    logic       req_bad_format = 1'b0;
    logic       s_valid = 1'b0;
    logic       s_perr = 1'b0;
    logic       s_cerr = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_func = 8'h00;
    logic [7:0] s_addr = 8'h00;
    logic [7:0] dly = 8'h04;
    logic [1:0] mode = 2'h0;
    logic [3:0] rmax = 4'h3;
    logic       m_valid, m_cerr, req_ready, tx_start, reply_ok, txn_err, timeout_err, busy;
    logic       slv_exec, slv_exec_bcast, slv_reply, slv_reply_err, exh;
    logic [7:0] m_addr, m_func, tx_addr, tx_func, reply_func, slv_reply_addr;
    int         bad_count = 0;
    int         total_checks = 0;
    int         n_tx = 0, n_ok = 0, n_slv = 0, n_serr = 0, n_bc = 0, n_ex = 0, n = 0;

    // 125 MHz reference
    always #4 ref_clk = ~ref_clk;

    // pulse tallies, taken on the sampling edge
    always @(posedge ref_clk) begin
        if (tx_start === 1'b1) n_tx <= n_tx + 1;
        if (reply_ok === 1'b1) n_ok <= n_ok + 1;
        if (slv_reply === 1'b1) n_slv <= n_slv + 1;
        if (slv_reply === 1'b1 && slv_reply_err === 1'b1) n_serr <= n_serr + 1;
        if (slv_exec_bcast === 1'b1) n_bc <= n_bc + 1;
        if (slv_exec === 1'b1) n_ex <= n_ex + 1;
    end

    // short timer values keep the run brief
    serial_txn #(.REPLY_TMO_CYC(200), .BCAST_GAP_CYC(20)) serial_txn_inst (
        .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req_addr(req_addr),
        .req_func(req_func), .req_is_write(req_is_write), .retry_max(rmax),
        .retry_on_frame_err(retry_on_frame_err), .rx_valid(slave_mode ? s_valid : m_valid),
        .rx_addr(slave_mode ? s_addr : m_addr), .rx_func(slave_mode ? 8'h06 : m_func),
        .rx_parity_err(s_perr), .rx_check_err(slave_mode ? s_cerr : m_cerr),
        .slave_mode(slave_mode), .my_addr(8'h2A), .req_bad_format(req_bad_format),
        .req_ready(req_ready), .tx_start(tx_start), .tx_addr(tx_addr), .tx_func(tx_func),
        .reply_ok(reply_ok), .reply_func(reply_func), .txn_err(txn_err),
        .timeout_err(timeout_err), .retries_exhausted(exh), .busy(busy), .slv_exec(slv_exec),
        .slv_exec_bcast(slv_exec_bcast), .slv_reply(slv_reply),
        .slv_reply_err(slv_reply_err), .slv_reply_addr(slv_reply_addr)
    );

    slave_node_model slave_node_model_inst (
        .ref_clk(ref_clk), .tx_start(tx_start), .tx_addr(tx_addr), .tx_func(tx_func),
        .mode(mode), .dly(dly), .rx_valid(m_valid), .rx_addr(m_addr), .rx_func(m_func),
        .rx_check_err(m_cerr)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic sig(input int w);
        case (w)
            0: return tx_start;
            1: return reply_ok;
            2: return timeout_err;
            3: return req_ready;
            default: return txn_err;
        endcase
    endfunction : sig

    // bounded wait; n tells how many edges it took
    task automatic wait_sig(input int w, input int lim);
        n = 0;
        while (sig(w) !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (sig(w) !== 1'b1) begin
            bad_count++;
            $display("ERROR output %0d expected 1 seen %b", w, sig(w));
            report_and_stop();
        end
    endtask : wait_sig

    // one request, held over the edge that sees req_ready
    task automatic send(input logic [7:0] a, input logic w);
        wait_sig(3, 400);
        @(posedge ref_clk);
        req_valid    <= 1'b1;
        req_addr     <= a;
        req_func     <= a ^ 8'h3C;
        req_is_write <= w;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        req_addr  <= ~a;
        #1;
    endtask : send

    task automatic t_unicast;
        int t0;
        t0 = n_tx;
        send(8'hF7, 1'b0);
        wait_sig(0, 4);
        check(tx_addr, 8'hF7, "tx_addr");
        check({busy, req_ready}, 2'h2, "busy ready");
        @(posedge ref_clk);
        req_valid <= 1'b1;   // offered while busy, must be ignored
        req_addr  <= 8'h05;
        repeat (3) @(posedge ref_clk);
        req_valid <= 1'b0;
        wait_sig(1, 40);
        check(reply_func, 8'hF7 ^ 8'h3C, "reply_func");
        check(n_tx - t0, 1, "launches");
        @(posedge ref_clk);
        #1;
        check(req_ready, 1, "ready after reply");
        $display("unicast done");
    endtask : t_unicast

    task automatic t_timeout;
        int t0;
        @(posedge ref_clk);
        mode <= 2'h1;
        dly  <= 8'h0A;
        rmax <= 4'h1;
        t0 = n_ok;
        // ceiling of one: the second timeout on the same slave is exhausted
        for (int i = 0; i < 2; i++) begin
            send(8'h22, 1'b0);
            wait_sig(0, 4);
            wait_sig(2, 300);
            check(n >= 190 && n <= 210, 1, "timeout cycles");
            check(txn_err, 1, "txn_err");
            check(exh, i == 1, "retries exhausted");
        end
        check(n_ok - t0, 0, "foreign reply");
        @(posedge ref_clk);
        #1;
        check(req_ready, 1, "idle after timeout");
        $display("timeout done");
    endtask : t_timeout

    task automatic t_retry;
        int t0;
        int t1;
        @(posedge ref_clk);
        mode               <= 2'h2;
        dly                <= 8'h04;
        retry_on_frame_err <= 1'b1;
        t0 = n_ok;
        send(8'h01, 1'b0);
        wait_sig(0, 4);
        @(posedge ref_clk);
        #1;
        wait_sig(0, 40);
        check(tx_addr, 8'h01, "resend addr");
        wait_sig(1, 40);
        check(reply_func, 8'h01 ^ 8'h3C, "retried reply");
        @(posedge ref_clk);
        retry_on_frame_err <= 1'b0;
        mode               <= 2'h0;
        repeat (2) @(posedge ref_clk);
        mode <= 2'h2;
        t1 = n_tx;
        send(8'h01, 1'b0);
        wait_sig(4, 40);
        repeat (4) @(posedge ref_clk);
        #1;
        check(n_tx - t1, 1, "no resend");
        check(n_ok - t0, 1, "damaged dropped");
        $display("retry done");
    endtask : t_retry

    task automatic t_bcast;
        logic [7:0] ra [3] = '{8'h00, 8'hF8, 8'hFF};
        int t0;
        t0 = n_ok;
        send(8'h00, 1'b1);
        wait_sig(0, 4);
        wait_sig(3, 60);
        check(n >= 19 && n <= 23, 1, "gap cycles");
        check(n_ok - t0, 0, "broadcast reply");
        t0 = n_tx;
        for (int i = 0; i < 3; i++) begin
            send(ra[i], i != 0);
            wait_sig(4, 3);
        end
        check(n_tx - t0, 0, "refused launches");
        $display("broadcast done");
    endtask : t_bcast

    // slave side: flags are perr, cerr, bad format, reply, broadcast exec
    task automatic t_slave;
        logic [7:0] ta [7] = '{8'h2A, 8'h00, 8'h2B, 8'h2A, 8'h2A, 8'h2A, 8'hF8};
        logic [4:0] tf [7] = '{5'h02, 5'h01, 5'h00, 5'h10, 5'h08, 5'h06, 5'h00};
        int r0;
        int e0;
        int b0;
        int x0;
        for (int i = 0; i < 7; i++) begin
            r0 = n_slv;
            e0 = n_serr;
            b0 = n_bc;
            x0 = n_ex;
            @(posedge ref_clk);
            slave_mode     <= 1'b1;
            s_valid        <= 1'b1;
            s_addr         <= ta[i];
            s_perr         <= tf[i][4];
            s_cerr         <= tf[i][3];
            req_bad_format <= tf[i][2];
            @(posedge ref_clk);
            s_valid <= 1'b0;
            s_addr  <= ~ta[i];
            repeat (6) @(posedge ref_clk);
            #1;
            check(n_slv - r0, tf[i][1], "slave reply");
            check(n_serr - e0, tf[i][2], "error reply");
            check(n_bc - b0, tf[i][0], "bcast exec");
            check(n_ex - x0, tf[i][0] | (tf[i][1] & ~tf[i][2]), "slave exec");
        end
        check(slv_reply_addr, 8'h2A, "reply addr");
        $display("slave done");
    endtask : t_slave

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        t_unicast();
        t_timeout();
        t_retry();
        t_bcast();
        t_slave();
        report_and_stop();
    end
endmodule : testbench
